// ===== hdl/embc_controller.v
// External memory bank controller: decode, strobes, stall and bus hold
//
// Summary of operation
// - Eight banks; banks 0-5 of 128 MB each
// - Banks 1-7 8/16/32 bit; bank 0 16/32
// - Banks 6 and 7 also serve SDRAM
// - Only bank 7 start moves with size
// - Bank 6 starts 0x3000_0000, length programmed size
// - Bank 7 follows directly after bank 6
// - Bank 0 width latched from straps on first clock after reset release
// - Straps: 32 gives 32 bit bank 0; NAND, 16 or test give 16
// - Memory A0 from address bit 0/1/2
// - SDRAM bank select from top bank bits
// - 128 MB four-bank 32 bit uses 26:25
// - Stall input stretches strobe while enabled
// - Stall sampled from access count minus one
// - Strobe released on third clock after stall high
// - Hold request low answered with grant low
// - Pins released while grant low
// - Grant withdrawn after request released
// - Software selects little or big endian
// - Access cycles programmed per bank
// - SDRAM self-refresh and power-down states
// - All counts in bus clock cycles
// - Per-bank stall enable, one enables
module embc_controller (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdata,
    input  wire        accReq,
    input  wire        accWrite,
    input  wire [29:0] accAddr,
    input  wire [31:0] accWdata,
    output wire        accBusy,
    output reg         accDone,
    output reg  [31:0] accRdata,
    input  wire [1:0]  boot_mode_straps,
    input  wire        ext_stall_n,
    input  wire        bus_hold_request_n,
    output reg         bus_hold_grant_n,
    output reg  [7:0]  bankSelectN,
    output reg  [25:0] memAddr,
    output reg  [1:0]  sdramBankAddr,
    output reg  [31:0] memDataOut,
    input  wire [31:0] memDataIn,
    output reg         read_strobe_n,
    output reg         write_strobe_n,
    output wire        pinOutEnableN,
    output reg         sdramSelfRefresh,
    output reg         sdramPowerDown
);
`include "embc_defs.vh"

    localparam ST_IDLE = 2'h0;
    localparam ST_ACC  = 2'h1;
    localparam ST_END  = 2'h2;

    // ************************************************************
    // Register file
    // ************************************************************
    reg [15:0] widthReg;
    reg [7:0]  bank7_stall_enable_vec;
    reg [2:0]  sizeReg;
    reg [3:0]  ctrlReg;
    reg [3:0]  accCyc [0:7];
    reg [1:0]  bank0WidthReg;
    reg        strapDone;
    reg [1:0]  stateReg;
    reg [3:0]  cntReg;
    reg [2:0]  bankReg;
    reg        wrReg;
    reg        stallMeta;
    reg        stallSync;
    reg        holdMeta;
    reg        holdSync;
    integer    i;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            widthReg <= `EMBC_WIDTH_RST;
            bank7_stall_enable_vec <= `EMBC_STALL_RST;
            sizeReg <= `EMBC_SIZE_RST;
            ctrlReg <= `EMBC_CTRL_RST;
            for (i = 0; i < 8; i = i + 1) begin
                accCyc[i] <= `EMBC_ACC_RST;
            end
        end else if (regWrite) begin
            case (regAddr)
                `EMBC_REG_WIDTH: widthReg <= regWdata[15:0];
                `EMBC_REG_STALL: bank7_stall_enable_vec <= regWdata[7:0];
                `EMBC_REG_SIZE:  sizeReg <= regWdata[2:0];
                `EMBC_REG_CTRL:  ctrlReg <= regWdata[3:0];
                default: begin
                    if (regAddr[3]) begin
                        accCyc[regAddr[2:0]] <= regWdata[3:0];
                    end
                end
            endcase
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            case (regAddr)
                `EMBC_REG_WIDTH:
                    regRdata <= {16'h0000, widthReg[15:2], bank0WidthReg};
                `EMBC_REG_STALL:  regRdata <= {24'h000000, bank7_stall_enable_vec};
                `EMBC_REG_SIZE:   regRdata <= {29'h00000000, sizeReg};
                `EMBC_REG_CTRL:   regRdata <= {28'h0000000, ctrlReg};
                `EMBC_REG_STATUS:
                    regRdata <= {26'h0000000, boot_mode_straps, stateReg,
                                 ~bus_hold_grant_n, stallSync};
                default: begin
                    regRdata <= regAddr[3] ?
                        {28'h0000000, accCyc[regAddr[2:0]]} : 32'h00000000;
                end
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    // ************************************************************
    // Boot straps and synchronisers
    // ************************************************************
    // Straps caught by a clocked process after release, never in reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bank0WidthReg <= `EMBC_BW16;
            strapDone <= 1'b0;
        end else if (!strapDone) begin
            strapDone <= 1'b1;
            bank0WidthReg <= (boot_mode_straps == `EMBC_BOOT_32) ?
                             `EMBC_BW32 : `EMBC_BW16;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stallMeta <= 1'b1;
            stallSync <= 1'b1;
            holdMeta <= 1'b1;
            holdSync <= 1'b1;
        end else begin
            stallMeta <= ext_stall_n;
            stallSync <= stallMeta;
            holdMeta <= bus_hold_request_n;
            holdSync <= holdMeta;
        end
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    reg [2:0]  decBank;
    reg        decHit;
    reg [29:0] b6Len;
    reg [1:0]  bw;
    reg [4:0]  topBit;
    reg [30:0] b6End;
    reg [30:0] b7End;
    always @* begin
        b6Len = 30'h00000001 << (`EMBC_MIN_SIZE_LOG + sizeReg);
        // One spare bit: at 128 MB bank 7 ends at the top of the map
        b6End = {1'b0, `EMBC_BANK67_BASE} + {1'b0, b6Len};
        b7End = b6End + {1'b0, b6Len};
        decHit = 1'b1;
        decBank = accAddr[29:27];
        if (accAddr[29:28] == 2'h3) begin
            if ({1'b0, accAddr} < b6End) begin
                decBank = 3'h6;
            end else if ({1'b0, accAddr} < b7End) begin
                decBank = 3'h7;
            end else begin
                decHit = 1'b0;
            end
        end
        bw = (decBank == 3'h0) ? bank0WidthReg :
             widthReg[{decBank, 1'b0} +: 2];
        // Top bank bit sits at log2(size)-1 for banks 6/7
        topBit = 5'd20 + {2'h0, sizeReg};
    end

    // ************************************************************
    // Access sequencer
    // ************************************************************
    wire holdActive = ~bus_hold_grant_n;
    assign accBusy = (stateReg != ST_IDLE) | holdActive;
    // Enable low while we drive; high hands the pins to the master
    assign pinOutEnableN = ~bus_hold_grant_n;

    wire stallOn = bank7_stall_enable_vec[bankReg];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg <= ST_IDLE;
            cntReg <= 4'h0;
            bankReg <= 3'h0;
            wrReg <= 1'b0;
            bankSelectN <= 8'hff;
            memAddr <= 26'h0000000;
            sdramBankAddr <= 2'h0;
            memDataOut <= 32'h00000000;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            accDone <= 1'b0;
            accRdata <= 32'h00000000;
            bus_hold_grant_n <= 1'b1;
            sdramSelfRefresh <= 1'b0;
            sdramPowerDown <= 1'b0;
        end else begin
            accDone <= 1'b0;
            sdramSelfRefresh <= ctrlReg[`EMBC_CTRL_SREF];
            sdramPowerDown <= ctrlReg[`EMBC_CTRL_PDOWN];
            case (stateReg)
                ST_IDLE: begin
                    if (!holdSync) begin
                        bus_hold_grant_n <= 1'b0;
                    end else begin
                        bus_hold_grant_n <= 1'b1;
                    end
                    if (accReq && holdSync && !holdActive && decHit) begin
                        stateReg <= ST_ACC;
                        bankReg <= decBank;
                        wrReg <= accWrite;
                        cntReg <= accCyc[decBank];
                        bankSelectN <= ~(8'h01 << decBank);
                        // Byte address shifted by width
                        memAddr <= accAddr[25:0] >> bw;
                        sdramBankAddr <= ctrlReg[`EMBC_CTRL_ORG4] ?
                            accAddr[topBit -: 2] :
                            {1'b0, accAddr[topBit]};
                        memDataOut <= ctrlReg[`EMBC_CTRL_BIGEND] ?
                            {accWdata[7:0], accWdata[15:8],
                             accWdata[23:16], accWdata[31:24]} :
                            accWdata;
                        read_strobe_n <= accWrite;
                        write_strobe_n <= ~accWrite;
                    end
                end
                ST_ACC: begin
                    if (cntReg > 4'h1) begin
                        cntReg <= cntReg - 4'h1;
                    end else if (!stallOn || stallSync) begin
                        // Stall seen from count-1 onward
                        stateReg <= ST_END;
                        read_strobe_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                        accRdata <= ctrlReg[`EMBC_CTRL_BIGEND] ?
                            {memDataIn[7:0], memDataIn[15:8],
                             memDataIn[23:16], memDataIn[31:24]} :
                            memDataIn;
                    end
                end
                ST_END: begin
                    bankSelectN <= 8'hff;
                    accDone <= 1'b1;
                    stateReg <= ST_IDLE;
                end
                default: stateReg <= ST_IDLE;
            endcase
        end
    end
endmodule // embc_controller

// ===== hdl/embc_defs.vh
// Constants for the external memory bank controller
`ifndef EMBC_DEFS_VH
`define EMBC_DEFS_VH
// Register indices (byte address = 4 * index)
`define EMBC_REG_WIDTH     4'h0
`define EMBC_REG_STALL     4'h1
`define EMBC_REG_SIZE      4'h2
`define EMBC_REG_CTRL      4'h3
`define EMBC_REG_STATUS    4'h4
`define EMBC_REG_ACC0      4'h8
// Reset values
`define EMBC_WIDTH_RST     16'h0000
`define EMBC_STALL_RST     8'h00
`define EMBC_SIZE_RST      3'h0
`define EMBC_CTRL_RST      4'h0
`define EMBC_ACC_RST       4'h7
// Control register fields
`define EMBC_CTRL_BIGEND   0
`define EMBC_CTRL_ORG4     1
`define EMBC_CTRL_SREF     2
`define EMBC_CTRL_PDOWN    3
// Address map
`define EMBC_BANK_SHIFT    27
`define EMBC_BANK67_BASE   30'h30000000
`define EMBC_BANK67_TOP    30'h3fffffff
`define EMBC_MIN_SIZE_LOG  21
// Bus widths
`define EMBC_BW8           2'h0
`define EMBC_BW16          2'h1
`define EMBC_BW32          2'h2
// Boot straps
`define EMBC_BOOT_NAND     2'h0
`define EMBC_BOOT_16       2'h1
`define EMBC_BOOT_32       2'h2
`define EMBC_BOOT_TEST     2'h3
`endif

// ===== testbench/embc_controller_props.sv
// Pin-level checks for the memory bank controller
`include "embc_defs.vh"
module embc_controller_props (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        accDone,
    input wire logic        bus_hold_request_n,
    input wire logic        bus_hold_grant_n,
    input wire logic [7:0]  bankSelectN,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        pinOutEnableN,
    input wire logic        sdramSelfRefresh,
    input wire logic        sdramPowerDown
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_pins_follow_grant: assert property (pinOutEnableN == !bus_hold_grant_n)
        else $error("pin enable disagrees with grant");
    // Two-flop synchroniser means the request is old news at grant time
    a_grant_needs_req: assert property ($fell(bus_hold_grant_n) |-> !$past(bus_hold_request_n, 2))
        else $error("grant without request");
    a_grant_answers: assert property ($fell(bus_hold_request_n) |-> ##[1:8] !bus_hold_grant_n)
        else $error("request not granted");
    a_grant_withdrawn: assert property ($rose(bus_hold_request_n) |-> ##[1:6] bus_hold_grant_n)
        else $error("grant kept after release");
    a_one_bank: assert property (!(&bankSelectN) |-> $onehot(~bankSelectN))
        else $error("several banks selected");
    a_strobe_in_bank: assert property (!read_strobe_n || !write_strobe_n |-> !(&bankSelectN))
        else $error("strobe without bank");
    a_strobes_apart: assert property (read_strobe_n || write_strobe_n)
        else $error("both strobes low");
    a_ctrl_copies: assert property (regWrite && regAddr == `EMBC_REG_CTRL |-> ##2 sdramSelfRefresh == $past(regWdata[`EMBC_CTRL_SREF], 2) && sdramPowerDown == $past(regWdata[`EMBC_CTRL_PDOWN], 2))
        else $error("sdram state bits wrong");
    a_read_quiet: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data outside slot");
    a_done_pulse: assert property (accDone |=> !accDone)
        else $error("done longer than a cycle");
endmodule // embc_controller_props

// ===== testbench/embc_mem_model.sv
// Behavioural external memory: answers reads and holds the stall pin
module embc_mem_model #(parameter logic [31:0] DATA = 32'ha5c30f96) (
    input  wire logic        clk,
    input  wire logic [7:0]  bankSelectN,
    input  wire logic        read_strobe_n,
    input  wire logic [7:0]  stallLen,
    output logic      [31:0] memDataIn,
    output logic             ext_stall_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  lowCnt = 8'h0;
    logic [31:0] junk   = 32'h0;
    wire         sel    = !(&bankSelectN);
    // Released bus flips every cycle so a late sample cannot pass
    assign memDataIn = (sel && !read_strobe_n) ? DATA : junk;
    // Stall from the first selected cycle, as a slow part would
    assign ext_stall_n = !(sel && lowCnt < stallLen);
    always @(posedge clk) begin
        junk   <= ~junk;
        lowCnt <= sel ? lowCnt + 8'h1 : 8'h0;
    end
endmodule // embc_mem_model

// ===== testbench/testbench.sv
// Self-checking bench for the memory bank controller
`include "embc_defs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] WORD = 32'ha5c30f96;
    localparam logic [31:0] WORD_SWAP = {WORD[7:0], WORD[15:8],
                                         WORD[23:16], WORD[31:24]};
    logic clk = 0, reset_n = 0, regWrite = 0, regRead = 0, accReq = 0;
    logic accWrite = 0, bus_hold_request_n = 1;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, accWdata = 32'h0, d, rdat;
    logic [29:0] accAddr = 30'h0;
    logic [1:0]  boot_mode_straps = `EMBC_BOOT_32;
    logic [7:0]  stallLen = 8'h0, sel;
    wire  [31:0] regRdata, accRdata, memDataOut, memDataIn;
    wire  [25:0] memAddr;
    wire  [7:0]  bankSelectN;
    wire  [1:0]  sdramBankAddr;
    wire accBusy, accDone, bus_hold_grant_n, read_strobe_n, write_strobe_n;
    wire pinOutEnableN, sdramSelfRefresh, sdramPowerDown, ext_stall_n;
    int n_errors = 0, cmp_count = 0, cyc = 0, n, t, k;
    embc_controller embc_controller_inst (.clk, .reset_n, .regAddr,
        .regWdata, .regWrite, .regRead, .regRdata, .accReq, .accWrite,
        .accAddr, .accWdata, .accBusy, .accDone, .accRdata,
        .boot_mode_straps, .ext_stall_n, .bus_hold_request_n,
        .bus_hold_grant_n, .bankSelectN, .memAddr, .sdramBankAddr,
        .memDataOut, .memDataIn, .read_strobe_n, .write_strobe_n,
        .pinOutEnableN, .sdramSelfRefresh, .sdramPowerDown);
    embc_mem_model #(.DATA(WORD)) embc_mem_model_inst (.clk, .bankSelectN,
        .read_strobe_n, .stallLen, .memDataIn, .ext_stall_n);
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            tally_and_finish();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 v = regRdata;
    endtask
    // Access, read or write per accWrite; counts strobe-low cycles and notes the bank selected
    task automatic acc(input logic [29:0] a);
        accAddr <= a;
        accReq <= 1'b1;
        @(posedge clk);
        accReq <= 1'b0;
        n = 0;
        for (t = 0; t < 80; t++) begin
            #1;
            if (accDone === 1'b1) break;
            if ((read_strobe_n & write_strobe_n) === 1'b0) begin
                if (n == 0) sel = bankSelectN;
                n++;
            end
            @(posedge clk);
        end
        rdat = accRdata;
        `CHK(accDone, 1'b1)
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`EMBC_REG_WIDTH, d); `CHK(d, 32'h2)
        rd(`EMBC_REG_ACC0, d); `CHK(d[3:0], `EMBC_ACC_RST)
        rd(4'h5, d); `CHK(d, 32'h0)
        // Bank 0 field must not take the write
        wr(`EMBC_REG_WIDTH, 32'h5);
        rd(`EMBC_REG_WIDTH, d); `CHK(d, 32'h6)
        wr(`EMBC_REG_ACC0, 32'h4);
        stallLen <= 8'd10;
        acc(30'h100); `CHK(n, 4)
        `CHK(sel, 8'hfe)
        `CHK(rdat, WORD)
        wr(`EMBC_REG_STALL, 32'h1);
        acc(30'h100); `CHK(n >= 10 && n <= 16, 1'b1)
        stallLen <= 8'd0;
        acc(30'h18000000); `CHK(sel, 8'hf7)
        for (k = 0; k < 7; k++) begin
            wr(`EMBC_REG_SIZE, k);
            acc(30'h30000000 + (30'h200000 << k) - 30'h4); `CHK(sel, 8'hbf)
            acc(30'h30000000 + (30'h200000 << k)); `CHK(sel, 8'h7f)
        end
        wr(`EMBC_REG_CTRL, 32'hc);
        @(posedge clk);
        #1 `CHK({sdramPowerDown, sdramSelfRefresh}, 2'h3)
        wr(`EMBC_REG_CTRL, 32'h0);
        // Bank 6 on a 32 bit bus, four-bank parts, 128 MB
        wr(`EMBC_REG_WIDTH, 32'h2000);
        wr(`EMBC_REG_CTRL, 32'h2);
        acc(30'h36000010); `CHK(memAddr, 26'h0800004)
        `CHK(sdramBankAddr, 2'h3)
        wr(`EMBC_REG_SIZE, 32'h0);
        wr(`EMBC_REG_CTRL, 32'h0);
        acc(30'h30100000); `CHK(sdramBankAddr, 2'h1)
        `CHK(memAddr, 26'h0040000)
        // Big-endian write then read on bank 0
        wr(`EMBC_REG_CTRL, 32'h1);
        accWrite <= 1'b1;
        accWdata <= 32'h11223344;
        acc(30'h100); `CHK(memDataOut, 32'h44332211)
        `CHK(n, 4)
        accWrite <= 1'b0;
        acc(30'h100); `CHK(rdat, WORD_SWAP)
        wr(`EMBC_REG_CTRL, 32'h0);
        bus_hold_request_n <= 1'b0;
        for (t = 0; t < 10 && bus_hold_grant_n !== 1'b0; t++) @(posedge clk);
        #1 `CHK(bus_hold_grant_n, 1'b0)
        `CHK(pinOutEnableN, 1'b1)
        `CHK(accBusy, 1'b1)
        bus_hold_request_n <= 1'b1;
        for (t = 0; t < 10 && bus_hold_grant_n !== 1'b1; t++) @(posedge clk);
        #1 `CHK(bus_hold_grant_n, 1'b1)
        `CHK(pinOutEnableN, 1'b0)
        `CHK(accBusy, 1'b0)
        // Second reset with 16 bit boot straps
        boot_mode_straps <= `EMBC_BOOT_16;
        reset_n <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`EMBC_REG_WIDTH, d); `CHK(d, 32'h1)
        acc(30'h100); `CHK(memAddr, 26'h0000080)
        tally_and_finish();
    end
endmodule // testbench
bind embc_controller embc_controller_props embc_controller_props_inst (
    .clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .accDone, .bus_hold_request_n, .bus_hold_grant_n, .bankSelectN,
    .read_strobe_n, .write_strobe_n, .pinOutEnableN, .sdramSelfRefresh,
    .sdramPowerDown);
